// ### logic/pmcb_pkg.sv
// shared constants and types for the pad mode configuration bank
package pmcb_pkg;

    localparam int NUM_PINS = 5;
    localparam int APB_AW   = 12;
    localparam int APB_DW   = 32;
    localparam int REG_W    = 16;

    // printed register offsets, kept as word indices
    localparam logic [31:0] IDX_P1_PIN6 = 32'h5000303a;
    localparam logic [31:0] IDX_P1_PIN7 = 32'h5000303c;
    localparam logic [31:0] IDX_P2_PIN0 = 32'h5000303e;
    localparam logic [31:0] IDX_P2_PIN1 = 32'h50003040;
    localparam logic [31:0] IDX_P2_PIN2 = 32'h50003042;
    localparam logic [NUM_PINS*32-1:0] IDX_TABLE =
        {IDX_P2_PIN2, IDX_P2_PIN1, IDX_P2_PIN0, IDX_P1_PIN7, IDX_P1_PIN6};

    // field positions
    localparam int DRIVE_TYPE_POS = 10;
    localparam int DIR_PULL_LSB   = 8;
    localparam int DIR_PULL_MSB   = 9;
    localparam int FUNC_SEL_LSB   = 0;
    localparam int FUNC_SEL_MSB   = 5;
    localparam logic [15:0] WRITABLE_MASK = 16'h073f;

    // direction / pull encodings
    localparam logic [1:0] DIR_IN_NOPULL = 2'h0;
    localparam logic [1:0] DIR_IN_PULLUP = 2'h1;
    localparam logic [1:0] DIR_IN_PULLDN = 2'h2;
    localparam logic [1:0] DIR_OUT       = 2'h3;

    // values after reset
    localparam logic       RST_DRIVE_TYPE = 1'h0;
    localparam logic [1:0] RST_DIR_FIRST  = 2'h1;
    localparam logic [1:0] RST_DIR_OTHER  = 2'h2;
    localparam logic [5:0] RST_FUNC_SEL   = 6'h00;

    typedef struct packed {
        logic drive_type_sel;
        logic [1:0] dir_pull_sel;
        logic [5:0] function_sel;
    } pmcb_mode_s;

    typedef struct packed {
        logic pad_oe_n;
        logic open_drain;
        logic pull_up_en;
        logic pull_dn_en;
    } pmcb_pad_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_ACCESS
    } pmcb_apb_e;

endpackage

// ### logic/pmcb_mode_reg.sv
// one pad mode register with byte-lane writes
`timescale 1ns/100ps
module pmcb_mode_reg
    import pmcb_pkg::*;
#(
    parameter logic [1:0] RST_DIR = RST_DIR_OTHER
)(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        wr_en,
    input  wire logic [1:0]  wr_strb,
    input  wire logic [15:0] wr_data,
    output pmcb_mode_s       mode_q,
    output logic [15:0]      rd_word
);

    pmcb_mode_s mode_d;

    // reserved bits are never stored, so they always read zero
    always_comb
    begin
        mode_d = mode_q;
        if (wr_en && wr_strb[1])
        begin
            mode_d.drive_type_sel = wr_data[DRIVE_TYPE_POS];
            mode_d.dir_pull_sel   = wr_data[DIR_PULL_MSB:DIR_PULL_LSB];
        end
        if (wr_en && wr_strb[0])
            mode_d.function_sel = wr_data[FUNC_SEL_MSB:FUNC_SEL_LSB];
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            mode_q.drive_type_sel <= RST_DRIVE_TYPE;
            mode_q.dir_pull_sel   <= RST_DIR;
            mode_q.function_sel   <= RST_FUNC_SEL;
        end
        else
            mode_q <= mode_d;
    end

    assign rd_word = {5'h00, mode_q.drive_type_sel, mode_q.dir_pull_sel,
                      2'h0, mode_q.function_sel};

endmodule

// ### logic/pmcb_pad_ctrl.sv
// decodes one mode register into registered pad controls
`timescale 1ns/100ps
module pmcb_pad_ctrl
    import pmcb_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset,
    input  pmcb_mode_s mode,
    input  wire logic adc_sel,
    output pmcb_pad_s pad_q
);

    function automatic logic is_output(input logic [1:0] dir);
        is_output = (dir == DIR_OUT);
    endfunction

    pmcb_pad_s pad_d;
    logic      dir_out;

    assign dir_out = is_output(mode.dir_pull_sel);

    // analog use overrides the direction/pull field completely
    assign pad_d.pad_oe_n   = adc_sel ? 1'b1 : !dir_out;
    assign pad_d.open_drain = mode.drive_type_sel;
    assign pad_d.pull_up_en = !adc_sel && (mode.dir_pull_sel == DIR_IN_PULLUP);
    assign pad_d.pull_dn_en = !adc_sel && (mode.dir_pull_sel == DIR_IN_PULLDN);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            pad_q <= '{pad_oe_n: 1'b1, open_drain: 1'b0, pull_up_en: 1'b0, pull_dn_en: 1'b0};
        else
            pad_q <= pad_d;
    end

endmodule

// ### logic/pmcb_top.sv
// apb register bank of five pad mode registers and their pad controls
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
module pmcb_top
    import pmcb_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                reset,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [APB_AW-1:0]   paddr,
    input  wire logic [APB_DW-1:0]   pwdata,
    input  wire logic [3:0]          pstrb,
    output logic                     pready,
    output logic [APB_DW-1:0]        prdata,
    output logic                     pslverr,
    input  wire logic [NUM_PINS-1:0] adc_sel,
    output pmcb_pad_s [NUM_PINS-1:0] pad_ctrl
);

    ////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic hit(input logic [APB_AW-1:0] a, input logic [31:0] idx);
        hit = (a[1:0] == 2'h0) && (a[APB_AW-1:2] == idx[APB_AW-3:0]);
    endfunction

    logic [NUM_PINS-1:0] sel_vec;
    logic                mapped;
    logic                pready_q;
    logic                pready_d;
    logic [APB_DW-1:0]   prdata_q;
    logic [APB_DW-1:0]   prdata_d;
    logic                pslverr_q;
    logic                commit;
    logic [15:0]         rd_words [NUM_PINS];
    pmcb_mode_s          modes    [NUM_PINS];

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++)
        begin : g_dec
            assign sel_vec[g] = hit(paddr, IDX_TABLE[g*32 +: 32]);
        end
    endgenerate

    assign mapped = |sel_vec;

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, answer registered

    // ready is raised one cycle into the access phase so all outputs come from flops
    assign pready_d = psel && penable && !pready_q;
    assign commit   = psel && penable && pready_q;

    always_comb
    begin
        prdata_d = '0;
        for (int i = 0; i < NUM_PINS; i++)
            if (sel_vec[i])
                prdata_d = {16'h0000, rd_words[i]};
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= pready_d;
            prdata_q  <= (pready_d && !pwrite) ? prdata_d : '0;
            pslverr_q <= pready_d && !mapped;
        end
    end

    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // registers and pad decode

    generate
        for (g = 0; g < NUM_PINS; g++)
        begin : g_pin
            pmcb_mode_reg #(
                .RST_DIR (g == 0 ? RST_DIR_FIRST : RST_DIR_OTHER)
            ) u_reg (
                .clk_sys (clk_sys),
                .reset   (reset),
                .wr_en   (commit && pwrite && sel_vec[g]),
                .wr_strb (pstrb[1:0]),
                .wr_data (pwdata[15:0]),
                .mode_q  (modes[g]),
                .rd_word (rd_words[g])
            );

            pmcb_pad_ctrl u_pad (
                .clk_sys (clk_sys),
                .reset   (reset),
                .mode    (modes[g]),
                .adc_sel (adc_sel[g]),
                .pad_q   (pad_ctrl[g])
            );

            ////////////////////////////////////////////////////////////////
            // checks

            a_drive_type: assert property (@(posedge clk_sys) disable iff (reset)
                1'b1 |=> pad_ctrl[g].open_drain == $past(modes[g].drive_type_sel))
                else $error("drive type does not follow register");

            a_input_pulls: assert property (@(posedge clk_sys) disable iff (reset)
                (!adc_sel[g] && modes[g].dir_pull_sel != DIR_OUT) |=>
                (pad_ctrl[g].pad_oe_n &&
                 pad_ctrl[g].pull_up_en == ($past(modes[g].dir_pull_sel) == DIR_IN_PULLUP) &&
                 pad_ctrl[g].pull_dn_en == ($past(modes[g].dir_pull_sel) == DIR_IN_PULLDN)))
                else $error("input pull selection wrong");

            a_output_mode: assert property (@(posedge clk_sys) disable iff (reset)
                (!adc_sel[g] && modes[g].dir_pull_sel == DIR_OUT) |=>
                (!pad_ctrl[g].pad_oe_n && !pad_ctrl[g].pull_up_en && !pad_ctrl[g].pull_dn_en))
                else $error("output mode wrong");

            a_adc_override: assert property (@(posedge clk_sys) disable iff (reset)
                adc_sel[g] |=> (pad_ctrl[g].pad_oe_n && !pad_ctrl[g].pull_up_en &&
                                !pad_ctrl[g].pull_dn_en))
                else $error("adc pin still steered by direction field");

            a_reset_value: assert property (@(posedge clk_sys)
                $fell(reset) |-> modes[g].dir_pull_sel == (g == 0 ? RST_DIR_FIRST : RST_DIR_OTHER)
                                 && modes[g].function_sel == RST_FUNC_SEL)
                else $error("reset value wrong");

            a_reserved_zero: assert property (@(posedge clk_sys) disable iff (reset)
                (rd_words[g] & ~WRITABLE_MASK) == 16'h0000)
                else $error("reserved bits not zero");
        end
    endgenerate

    a_write_lands: assert property (@(posedge clk_sys) disable iff (reset)
        (commit && pwrite && sel_vec[0] && pstrb[1]) |=>
        modes[0].dir_pull_sel == $past(pwdata[DIR_PULL_MSB:DIR_PULL_LSB]))
        else $error("write did not land");

    a_ready_timing: assert property (@(posedge clk_sys) disable iff (reset)
        (psel && !penable) ##1 (psel && penable) |-> ##1 pready)
        else $error("ready late");

    a_read_data: assert property (@(posedge clk_sys) disable iff (reset)
        (pready && !pwrite && !pslverr) |-> prdata[31:16] == 16'h0000)
        else $error("upper read data not zero");

endmodule

// ### bench/pad_mode_config_bank_test.sv
// self-checking testbench for the pad mode configuration bank
`timescale 1ns/100ps
module pad_mode_config_bank_test
    import pmcb_pkg::*;
;
    typedef struct packed {
        logic [2:0]  pin;
        logic [15:0] wdata;
        logic        adc;
        logic [15:0] rd;
        logic [3:0]  pad;
    } pmcb_row_s;
    // pad column is {oe_n, open_drain, pull_up, pull_dn}
    localparam pmcb_row_s ROWS [7] = '{
        '{3'h0, 16'hffff, 1'h0, 16'h073f, 4'h4},
        '{3'h1, 16'h0000, 1'h0, 16'h0000, 4'h8},
        '{3'h2, 16'h0115, 1'h0, 16'h0115, 4'ha},
        '{3'h3, 16'h062a, 1'h0, 16'h062a, 4'hd},
        '{3'h4, 16'h0300, 1'h1, 16'h0300, 4'h8},
        '{3'h4, 16'h0300, 1'h0, 16'h0300, 4'h0},
        '{3'h2, 16'h0100, 1'h1, 16'h0100, 4'h8}};

    logic                    clk_sys;
    logic                    reset;
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [APB_AW-1:0]       paddr;
    logic [APB_DW-1:0]       pwdata;
    logic [3:0]              pstrb;
    logic                    pready;
    logic [APB_DW-1:0]       prdata;
    logic                    pslverr;
    logic [NUM_PINS-1:0]     adc_sel;
    pmcb_pad_s [NUM_PINS-1:0] pad_ctrl;
    logic [31:0]             rdata;
    logic                    rerr;
    int                      fail_count = 0;
    int                      checked = 0;
    int                      cycles = 0;

    pmcb_top uut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .adc_sel(adc_sel), .pad_ctrl(pad_ctrl));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] addr_of(input int p);
        // printed offsets are word indices; the bus sees the low 12 bits of 4*index
        return 12'(IDX_TABLE[p*32 +: 32] << 2);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pad(input pmcb_pad_s got, input logic [3:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        // one idle edge first, so no strobe is assigned twice in one step
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        pstrb  <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic summarize;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles > 3000)
        begin
            fail_count++;
            summarize();
        end
    end

    initial
    begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        adc_sel = '0;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk_pad(pad_ctrl[0], 4'ha);
        for (int i = 1; i < NUM_PINS; i++)
            chk_pad(pad_ctrl[i], 4'h9);
        for (int i = 0; i < NUM_PINS; i++)
        begin
            apb(1'b0, addr_of(i), 32'h0, 4'h0, rdata, rerr);
            chk(rdata, (i == 0) ? 32'h0100 : 32'h0200);
        end
        foreach (ROWS[r])
        begin
            adc_sel <= 5'(ROWS[r].adc) << ROWS[r].pin;
            apb(1'b1, addr_of(ROWS[r].pin), {16'hffff, ROWS[r].wdata}, 4'hf, rdata, rerr);
            chk({31'h0, rerr}, 32'h0);
            apb(1'b0, addr_of(ROWS[r].pin), 32'h0, 4'h0, rdata, rerr);
            chk(rdata, {16'h0, ROWS[r].rd});
            chk_pad(pad_ctrl[ROWS[r].pin], ROWS[r].pad);
        end
        // partial byte lanes: only the enabled lane may change
        adc_sel <= '0;
        apb(1'b1, addr_of(1), 32'hffff, 4'h1, rdata, rerr);
        apb(1'b0, addr_of(1), 32'h0, 4'h0, rdata, rerr);
        chk(rdata, 32'h003f);
        apb(1'b1, addr_of(0), 32'h0, 4'h2, rdata, rerr);
        apb(1'b0, addr_of(0), 32'h0, 4'h0, rdata, rerr);
        chk(rdata, 32'h003f);
        chk_pad(pad_ctrl[0], 4'h8);
        // unmapped address between two registers
        apb(1'b1, 12'h0ec, 32'hffff, 4'hf, rdata, rerr);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b0, 12'h0ec, 32'h0, 4'h0, rdata, rerr);
        chk({rdata[30:0], rerr}, 32'h1);
        apb(1'b0, addr_of(0), 32'h0, 4'h0, rdata, rerr);
        chk(rdata, 32'h003f);
        // second reset in mid-run
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        apb(1'b0, addr_of(0), 32'h0, 4'h0, rdata, rerr);
        chk(rdata, 32'h0100);
        apb(1'b0, addr_of(4), 32'h0, 4'h0, rdata, rerr);
        chk(rdata, 32'h0200);
        summarize();
    end
endmodule
